// file: core/qdm_defs.svh
`ifndef QDM_DEFS_SVH
`define QDM_DEFS_SVH
// Operation
// - Four channels run transfers independently.
// - Each channel keeps its own settings.
// - Uninterrupted bursts of 1, 2, 4 or 8 bytes.
// - Block size one byte up to 64 KB.
// - Repeat counter reruns block, up to 16 MB.
// - Addresses fixed, incremented or decremented per byte.
// - Optional address reload per burst, block, transaction.
// - Trigger by software, peripheral or routed event.
// - Channel interrupt on completion or error.
// - Linked channel pair continues each other.
// - Moved data optionally fed to CRC generator.
// - SRAM, peripheral and register-to-register transfers.
// - Memory-mapped EEPROM usable as read source.
// - Separate read and write sides access concurrently.
// - I/O register access takes one cycle.
// - SRAM write one cycle, read two cycles.
// - SRAM burst read delivers byte every cycle.
// - EEPROM buffer write one cycle, read three.
// - EEPROM burst read delivers byte every second cycle.

// ----------------------------------------------------------------------
// Register map: byte address = channel * 0x20 + select * 4.
// ----------------------------------------------------------------------
`define QDM_NCH          4
`define QDM_CH_STRIDE    8'h20
`define QDM_SEL_CTRL     3'h0
`define QDM_SEL_ADDRCTL  3'h1
`define QDM_SEL_BLOCK    3'h2
`define QDM_SEL_REPEAT   3'h3
`define QDM_SEL_SRC      3'h4
`define QDM_SEL_DST      3'h5
`define QDM_SEL_STATUS   3'h6
`define QDM_SEL_REMAIN   3'h7

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define QDM_CTRL_EN      0
`define QDM_CTRL_SWREQ   1
`define QDM_CTRL_BURST   2
`define QDM_CTRL_REPEAT  4
`define QDM_CTRL_DONEIE  5
`define QDM_CTRL_ERRIE   6
`define QDM_CTRL_TRIG    7
`define QDM_CTRL_PRIO    9
`define QDM_CTRL_CRC     11
`define QDM_CTRL_LINK    12
`define QDM_AC_SMODE     0
`define QDM_AC_SRLD      2
`define QDM_AC_DMODE     4
`define QDM_AC_DRLD      6
`define QDM_ST_BUSY      0
`define QDM_ST_DONE      1
`define QDM_ST_ERR       2

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define QDM_RST_CTRL     16'h0000
`define QDM_RST_ADDRCTL  8'h00
`define QDM_RST_BLOCK    16'h0001
`define QDM_RST_REPEAT   8'h01
`define QDM_RST_ADDR     16'h0000

// ----------------------------------------------------------------------
// Data memory sections and access timing in clock cycles.
// ----------------------------------------------------------------------
`define QDM_IO_END       16'h0FFF
`define QDM_EE_BASE      16'h1000
`define QDM_EE_END       16'h1FFF
`define QDM_SRAM_BASE    16'h2000
`define QDM_SRAM_END     16'h5FFF
`define QDM_LAT_IO       2'h1
`define QDM_LAT_SRAM     2'h2
`define QDM_LAT_EE       2'h3
`define QDM_GAP_IO       2'h1
`define QDM_GAP_SRAM     2'h1
`define QDM_GAP_EE       2'h2
`define QDM_RESP_OKAY    2'h0
`define QDM_RESP_SLVERR  2'h2

`endif

// file: core/qdm_pkg.sv
package qdm_pkg;
  typedef enum logic [1:0] {AM_FIX, AM_INC, AM_DEC, AM_RSV} qdm_amode_t;
  typedef enum logic [1:0] {RL_NONE, RL_BURST, RL_BLOCK, RL_TRANS} qdm_reload_t;
  typedef enum logic [1:0] {TRG_SW, TRG_PER, TRG_EVT, TRG_RSV} qdm_trig_t;
  typedef enum logic [1:0] {RG_IO, RG_EE, RG_SRAM, RG_BAD} qdm_region_t;
  typedef enum {ST_IDLE, ST_BURST, ST_WB} qdm_state_t;
  typedef struct packed {
    logic        stb;
    logic [15:0] addr;
    logic [7:0]  data;
  } qdm_mem_t;
  typedef struct packed {
    logic       stb;
    logic [7:0] data;
  } qdm_byte_t;
endpackage

// file: core/qdm_top.sv
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "qdm_defs.svh"
module qdm_top (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [3:0]        per_req,
  input  wire logic [3:0]        evt_req,
  output qdm_pkg::qdm_mem_t      mem_rd,
  input  wire logic [7:0]        mem_rdata,
  output qdm_pkg::qdm_mem_t      mem_wr,
  output qdm_pkg::qdm_byte_t     crc_out,
  output logic [3:0]             ch_irq
);

  // ----------------------------------------------------------------------
  // Per-channel storage.
  // ----------------------------------------------------------------------
  logic [15:0]          ctrl_q [`QDM_NCH];
  logic [7:0]           actl_q [`QDM_NCH];
  logic [15:0]          blk_q  [`QDM_NCH];
  logic [7:0]           rep_q  [`QDM_NCH];
  logic [15:0]          src_q  [`QDM_NCH];
  logic [15:0]          dst_q  [`QDM_NCH];
  logic [15:0]          ws_q   [`QDM_NCH];
  logic [15:0]          wd_q   [`QDM_NCH];
  logic [16:0]          wb_q   [`QDM_NCH];
  logic [8:0]           wr_q   [`QDM_NCH];
  logic                 en_q   [`QDM_NCH];
  logic                 pend_q [`QDM_NCH];
  logic                 done_q [`QDM_NCH];
  logic                 err_q  [`QDM_NCH];
  logic                 irq_q  [`QDM_NCH];
  logic [3:0]           req;

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  function automatic qdm_pkg::qdm_region_t region(input logic [15:0] a);
    if (a <= `QDM_IO_END) region = qdm_pkg::RG_IO;
    else if (a >= `QDM_EE_BASE && a <= `QDM_EE_END) region = qdm_pkg::RG_EE;
    else if (a >= `QDM_SRAM_BASE && a <= `QDM_SRAM_END) region = qdm_pkg::RG_SRAM;
    else region = qdm_pkg::RG_BAD;
  endfunction

  function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m);
    case (qdm_pkg::qdm_amode_t'(m))
      qdm_pkg::AM_INC: step = a + 16'h0001;
      qdm_pkg::AM_DEC: step = a - 16'h0001;
      default:         step = a;
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input logic [1:0] c, input logic [2:0] s);
    case (s)
      `QDM_SEL_CTRL:    rd_word = {16'h0000, ctrl_q[c][15:2], 1'b0, en_q[c]};
      `QDM_SEL_ADDRCTL: rd_word = {24'h000000, actl_q[c]};
      `QDM_SEL_BLOCK:   rd_word = {16'h0000, blk_q[c]};
      `QDM_SEL_REPEAT:  rd_word = {24'h000000, rep_q[c]};
      `QDM_SEL_SRC:     rd_word = {16'h0000, src_q[c]};
      `QDM_SEL_DST:     rd_word = {16'h0000, dst_q[c]};
      `QDM_SEL_STATUS:  rd_word = {29'h00000000, err_q[c], done_q[c], en_q[c]};
      default:          rd_word = {6'h00, wr_q[c], wb_q[c]};
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // AXI4-Lite slave.
  // ----------------------------------------------------------------------
  wire        wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire        rd_fire = s_axi_arvalid && s_axi_arready;
  wire [1:0]  wr_ch   = s_axi_awaddr[6:5];
  wire [2:0]  wr_sel  = s_axi_awaddr[4:2];
  wire        wr_map  = !s_axi_awaddr[7];
  wire        rd_map  = !s_axi_araddr[7];
  wire [31:0] wmask   = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wmerged = (rd_word(wr_ch, wr_sel) & ~wmask) | (s_axi_wdata & wmask);
  wire [31:0] w1c     = s_axi_wdata & wmask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `QDM_RESP_OKAY;
    end else begin
      s_axi_awready <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
      s_axi_wready  <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `QDM_RESP_OKAY : `QDM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `QDM_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_map ? rd_word(s_axi_araddr[6:5], s_axi_araddr[4:2]) : 32'h00000000;
        s_axi_rresp  <= rd_map ? `QDM_RESP_OKAY : `QDM_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Arbiter: highest priority field wins, lower index breaks ties.
  // ----------------------------------------------------------------------
  logic       found;
  logic [1:0] win;
  logic [1:0] bestp;

  always_comb begin
    found = 1'b0;
    win   = 2'h0;
    bestp = 2'h0;
    for (int k = 0; k < `QDM_NCH; k++) begin
      if (req[k] && (!found || ctrl_q[k][`QDM_CTRL_PRIO+:2] > bestp)) begin
        found = 1'b1;
        win   = 2'(k);
        bestp = ctrl_q[k][`QDM_CTRL_PRIO+:2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transfer engine.
  // ----------------------------------------------------------------------
  qdm_pkg::qdm_state_t st_q;
  logic [1:0]          act_q;
  logic [15:0]         e_src_q;
  logic [15:0]         e_dst_q;
  logic [16:0]         e_blk_q;
  logic [8:0]          e_rep_q;
  logic [3:0]          icnt_q;
  logic [3:0]          rcnt_q;
  logic [1:0]          gap_q;
  logic [1:0]          gapv_q;
  logic [1:0]          lat_q;
  logic [2:0]          sr_q;
  logic [1:0]          lat_d;
  logic [1:0]          gapv_d;

  wire                 grant   = (st_q == qdm_pkg::ST_IDLE) && found;
  wire [3:0]           blen    = 4'h1 << ctrl_q[win][`QDM_CTRL_BURST+:2];
  wire [16:0]          wbw     = wb_q[win];
  wire [3:0]           nbytes  = (wbw < {13'h0000, blen}) ? wbw[3:0] : blen;
  wire [15:0]          a_ctrl  = ctrl_q[act_q];
  wire [7:0]           a_actl  = actl_q[act_q];
  wire                 src_bad = region(e_src_q) == qdm_pkg::RG_BAD;
  wire                 dst_bad = region(e_dst_q) == qdm_pkg::RG_BAD;
  wire                 bursting = st_q == qdm_pkg::ST_BURST;
  wire                 try_rd  = bursting && icnt_q != 4'h0 && gap_q == 2'h0;
  wire                 issue   = try_rd && !src_bad;
  wire                 tap     = (lat_q == 2'h1) ? sr_q[0] : (lat_q == 2'h2) ? sr_q[1] : sr_q[2];
  wire                 cap     = bursting && tap;
  wire                 eng_err = (try_rd && src_bad) || (cap && dst_bad);
  wire                 wb_fire = st_q == qdm_pkg::ST_WB;

  // Access timing follows the section that the source starts in.
  always_comb begin
    case (region(ws_q[win]))
      qdm_pkg::RG_EE: begin
        lat_d  = `QDM_LAT_EE;
        gapv_d = `QDM_GAP_EE;
      end
      qdm_pkg::RG_SRAM: begin
        lat_d  = `QDM_LAT_SRAM;
        gapv_d = `QDM_GAP_SRAM;
      end
      default: begin
        lat_d  = `QDM_LAT_IO;
        gapv_d = `QDM_GAP_IO;
      end
    endcase
  end

  // Write-back values at the end of a burst.
  wire        blk_end   = e_blk_q == 17'h00000;
  wire        trans_end = blk_end && (!a_ctrl[`QDM_CTRL_REPEAT] || e_rep_q <= 9'h001);
  wire [1:0]  srl       = a_actl[`QDM_AC_SRLD+:2];
  wire [1:0]  drl       = a_actl[`QDM_AC_DRLD+:2];
  wire        src_rl    = srl == qdm_pkg::RL_BURST || (srl == qdm_pkg::RL_BLOCK && blk_end)
                          || (srl == qdm_pkg::RL_TRANS && trans_end);
  wire        dst_rl    = drl == qdm_pkg::RL_BURST || (drl == qdm_pkg::RL_BLOCK && blk_end)
                          || (drl == qdm_pkg::RL_TRANS && trans_end);
  wire [15:0] nsrc      = src_rl ? src_q[act_q] : e_src_q;
  wire [15:0] ndst      = dst_rl ? dst_q[act_q] : e_dst_q;
  wire [16:0] nblk      = blk_end ? {blk_q[act_q] == 16'h0000, blk_q[act_q]} : e_blk_q;
  wire [8:0]  nrep      = blk_end ? e_rep_q - 9'h001 : e_rep_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= qdm_pkg::ST_IDLE;
      act_q   <= 2'h0;
      e_src_q <= 16'h0000;
      e_dst_q <= 16'h0000;
      e_blk_q <= 17'h00000;
      e_rep_q <= 9'h000;
      icnt_q  <= 4'h0;
      rcnt_q  <= 4'h0;
      gap_q   <= 2'h0;
      gapv_q  <= 2'h1;
      lat_q   <= 2'h1;
      sr_q    <= 3'h0;
      mem_rd  <= '0;
      mem_wr  <= '0;
      crc_out <= '0;
    end else begin
      mem_rd.stb  <= issue;
      mem_wr.stb  <= cap && !dst_bad;
      crc_out.stb <= cap && !dst_bad && a_ctrl[`QDM_CTRL_CRC];
      sr_q        <= {sr_q[1:0], issue};
      gap_q       <= issue ? gapv_q - 2'h1 : (gap_q != 2'h0 ? gap_q - 2'h1 : 2'h0);
      if (issue) begin
        mem_rd.addr <= e_src_q;
        e_src_q     <= step(e_src_q, a_actl[`QDM_AC_SMODE+:2]);
        icnt_q      <= icnt_q - 4'h1;
      end
      if (cap && !dst_bad) begin
        mem_wr.addr  <= e_dst_q;
        mem_wr.data  <= mem_rdata;
        crc_out.data <= mem_rdata;
        e_dst_q      <= step(e_dst_q, a_actl[`QDM_AC_DMODE+:2]);
        e_blk_q      <= e_blk_q - 17'h00001;
        rcnt_q       <= rcnt_q - 4'h1;
      end
      case (st_q)
        qdm_pkg::ST_IDLE: begin
          if (found) begin
            st_q    <= qdm_pkg::ST_BURST;
            act_q   <= win;
            e_src_q <= ws_q[win];
            e_dst_q <= wd_q[win];
            e_blk_q <= wb_q[win];
            e_rep_q <= wr_q[win];
            icnt_q  <= nbytes;
            rcnt_q  <= nbytes;
            gap_q   <= 2'h0;
            gapv_q  <= gapv_d;
            lat_q   <= lat_d;
            sr_q    <= 3'h0;
          end
        end
        qdm_pkg::ST_BURST: begin
          if (eng_err) st_q <= qdm_pkg::ST_IDLE;
          else if (cap && rcnt_q == 4'h1) st_q <= qdm_pkg::ST_WB;
        end
        qdm_pkg::ST_WB: st_q <= qdm_pkg::ST_IDLE;
        default:        st_q <= qdm_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Channels.
  // ----------------------------------------------------------------------
  generate
    for (genvar i = 0; i < `QDM_NCH; i++) begin : g_ch
      localparam logic [1:0] CH = 2'(i);
      localparam int         PT = i ^ 1;
      wire hit    = wr_fire && wr_map && wr_ch == CH;
      wire wctrl  = hit && wr_sel == `QDM_SEL_CTRL;
      wire own    = act_q == CH;
      wire fin    = wb_fire && own && trans_end;
      wire stop   = fin || (eng_err && own);
      wire lnk    = wb_fire && trans_end && act_q == 2'(PT) && ctrl_q[PT][`QDM_CTRL_LINK];
      wire start  = (wctrl && wmerged[`QDM_CTRL_EN] && !en_q[i]) || lnk;
      wire [1:0] tsel = ctrl_q[i][`QDM_CTRL_TRIG+:2];
      wire trg    = (wctrl && wmerged[`QDM_CTRL_SWREQ] && tsel == qdm_pkg::TRG_SW)
                    || (per_req[i] && tsel == qdm_pkg::TRG_PER)
                    || (evt_req[i] && tsel == qdm_pkg::TRG_EVT);

      assign req[i]    = en_q[i] && pend_q[i];
      assign ch_irq[i] = irq_q[i];

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ctrl_q[i] <= `QDM_RST_CTRL;
          actl_q[i] <= `QDM_RST_ADDRCTL;
          blk_q[i]  <= `QDM_RST_BLOCK;
          rep_q[i]  <= `QDM_RST_REPEAT;
          src_q[i]  <= `QDM_RST_ADDR;
          dst_q[i]  <= `QDM_RST_ADDR;
        end else if (hit) begin
          case (wr_sel)
            `QDM_SEL_CTRL:    ctrl_q[i] <= wmerged[15:0];
            `QDM_SEL_ADDRCTL: actl_q[i] <= wmerged[7:0];
            `QDM_SEL_BLOCK:   blk_q[i]  <= wmerged[15:0];
            `QDM_SEL_REPEAT:  rep_q[i]  <= wmerged[7:0];
            `QDM_SEL_SRC:     src_q[i]  <= wmerged[15:0];
            `QDM_SEL_DST:     dst_q[i]  <= wmerged[15:0];
            default:          ;
          endcase
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ws_q[i] <= `QDM_RST_ADDR;
          wd_q[i] <= `QDM_RST_ADDR;
          wb_q[i] <= 17'h00001;
          wr_q[i] <= 9'h001;
        end else if (start) begin
          ws_q[i] <= lnk ? src_q[i] : (hit && wr_sel == `QDM_SEL_SRC) ? wmerged[15:0] : src_q[i];
          wd_q[i] <= dst_q[i];
          wb_q[i] <= {blk_q[i] == 16'h0000, blk_q[i]};
          wr_q[i] <= {rep_q[i] == 8'h00, rep_q[i]};
        end else if (wb_fire && own) begin
          ws_q[i] <= nsrc;
          wd_q[i] <= ndst;
          wb_q[i] <= nblk;
          wr_q[i] <= nrep;
        end
      end

      // Flags set by hardware win over a clear in the same cycle.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          en_q[i]   <= 1'b0;
          pend_q[i] <= 1'b0;
          done_q[i] <= 1'b0;
          err_q[i]  <= 1'b0;
          irq_q[i]  <= 1'b0;
        end else begin
          if (start) en_q[i] <= 1'b1;
          else if (stop) en_q[i] <= 1'b0;
          else if (wctrl) en_q[i] <= wmerged[`QDM_CTRL_EN];
          if (trg && en_q[i]) pend_q[i] <= 1'b1;
          else if ((grant && win == CH) || !en_q[i]) pend_q[i] <= 1'b0;
          if (fin) done_q[i] <= 1'b1;
          else if (hit && wr_sel == `QDM_SEL_STATUS && w1c[`QDM_ST_DONE]) done_q[i] <= 1'b0;
          if (eng_err && own) err_q[i] <= 1'b1;
          else if (hit && wr_sel == `QDM_SEL_STATUS && w1c[`QDM_ST_ERR]) err_q[i] <= 1'b0;
          irq_q[i]  <= (done_q[i] && ctrl_q[i][`QDM_CTRL_DONEIE])
                       || (err_q[i] && ctrl_q[i][`QDM_CTRL_ERRIE]);
        end
      end
    end
  endgenerate

endmodule // qdm_top

// file: tb/qdm_mem_model.sv
`timescale 1ns/1ps
`include "qdm_defs.svh"
module qdm_mem_model (
  input wire qdm_pkg::qdm_mem_t mem_rd,
  input wire qdm_pkg::qdm_mem_t mem_wr,
  input wire logic              aclk,
  output logic [7:0]            mem_rdata
);
  logic [7:0]        mem [0:24575];
  logic [7:0]        junk = 8'h00;
  qdm_pkg::qdm_mem_t d1 = '0, d2 = '0;
  function automatic logic [1:0] lat(input logic [15:0] a);
    return (a <= `QDM_IO_END) ? `QDM_LAT_IO : (a < `QDM_SRAM_BASE) ? `QDM_LAT_EE : `QDM_LAT_SRAM;
  endfunction
  initial begin
    for (int i = 0; i < 24576; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
  end
  // Outside a valid read slot the data lines show a moving pattern.
  always @(posedge aclk) begin
    d1 <= mem_rd;
    d2 <= d1;
    junk <= junk + 8'h3B;
    if (mem_wr.stb) mem[mem_wr.addr] <= mem_wr.data;
  end
  assign mem_rdata = (mem_rd.stb && lat(mem_rd.addr) == `QDM_LAT_IO) ? mem[mem_rd.addr] :
    (d1.stb && lat(d1.addr) == `QDM_LAT_SRAM) ? mem[d1.addr] :
    (d2.stb && lat(d2.addr) == `QDM_LAT_EE) ? mem[d2.addr] : junk;
endmodule // qdm_mem_model

// file: tb/qdm_props.sv
`timescale 1ns/1ps
`include "qdm_defs.svh"
module qdm_props (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire qdm_pkg::qdm_mem_t  mem_rd,
  input wire qdm_pkg::qdm_mem_t  mem_wr,
  input wire qdm_pkg::qdm_byte_t crc_out
);
  wire rd_io = mem_rd.addr <= `QDM_IO_END;
  wire rd_ee = mem_rd.addr >= `QDM_EE_BASE && mem_rd.addr <= `QDM_EE_END;
  wire rd_sr = mem_rd.addr >= `QDM_SRAM_BASE && mem_rd.addr <= `QDM_SRAM_END;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_io_latency: assert property (mem_rd.stb && rd_io |-> ##1 mem_wr.stb)
    else $error("io read not written back one cycle later");
  chk_sram_latency: assert property (mem_rd.stb && rd_sr |-> ##2 mem_wr.stb)
    else $error("sram read not written back two cycles later");
  chk_ee_latency: assert property (mem_rd.stb && rd_ee |-> ##3 mem_wr.stb)
    else $error("eeprom read not written back three cycles later");
  chk_ee_spacing: assert property (mem_rd.stb && rd_ee |=> !mem_rd.stb)
    else $error("eeprom reads closer than two cycles");
  chk_sram_stream: assert property ((mem_rd.stb && rd_sr) ##1 !mem_rd.stb |=> !mem_rd.stb)
    else $error("sram burst read with a gap");
  chk_write_cause: assert property (mem_wr.stb |-> $past(mem_rd.stb, 1) ||
    $past(mem_rd.stb, 2) || $past(mem_rd.stb, 3)) else $error("write without a read");
  chk_legal_addr: assert property (mem_rd.stb || mem_wr.stb |->
    (!mem_rd.stb || rd_io || rd_ee || rd_sr) && (!mem_wr.stb || mem_wr.addr <= `QDM_SRAM_END))
    else $error("access outside the memory sections");
  chk_crc_copy: assert property (crc_out.stb |-> mem_wr.stb && crc_out.data == mem_wr.data)
    else $error("crc byte differs from written byte");
  cover property (mem_rd.stb && rd_ee);
  cover property (crc_out.stb);
  cover property (mem_wr.stb && mem_wr.addr <= `QDM_IO_END);
endmodule // qdm_props

bind qdm_top qdm_props chk_u (.aclk(aclk), .aresetn(aresetn), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .crc_out(crc_out));

// file: tb/test_qdm_top.sv
`timescale 1ns/1ps
module test_qdm_top;
  logic               aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, mem_rdata;
  logic [31:0]        s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
  logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic               s_axi_arvalid = 0, s_axi_rready = 0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp, resp_q;
  logic [3:0]         per_req = 4'h0, evt_req = 4'h0, ch_irq;
  qdm_pkg::qdm_mem_t  mem_rd, mem_wr;
  qdm_pkg::qdm_byte_t crc_out;
  logic [7:0]         crc_seen = 8'h00;
  int                 fail_count = 0, checks_done = 0, cyc = 0, crc_n = 0;
  qdm_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .per_req(per_req), .evt_req(evt_req), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .mem_wr(mem_wr), .crc_out(crc_out), .ch_irq(ch_irq));
  qdm_mem_model mdl_u (.aclk(aclk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata));
  function automatic logic [7:0] ra(input int ch, input int sel);
    return 8'(ch * 32 + sel * 4);
  endfunction
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp_q = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_flag(input int ch, input int b);
    rd_q = 32'h0;
    for (int i = 0; i < 40 && rd_q[b] !== 1'b1; i++) rd(ra(ch, 6));
    chk("status flag", 32'h1, {31'h0, rd_q[b]});
  endtask
  task automatic t_reset();
    rd(ra(1, 0));
    chk("ctrl reset", 32'h0, rd_q);
    rd(ra(1, 2));
    chk("block reset", 32'h1, rd_q);
    rd(ra(1, 3));
    chk("repeat reset", 32'h1, rd_q);
    rd(8'h80);
    chk("unmapped read resp", {30'h0, `QDM_RESP_SLVERR}, {30'h0, resp_q});
    wr(8'h84, 32'h1);
    chk("unmapped write resp", {30'h0, `QDM_RESP_SLVERR}, {30'h0, resp_q});
  endtask
  // Two-byte bursts, block of 2 repeated twice, source reloaded each block.
  task automatic t_sram_repeat();
    wr(ra(0, 1), 32'h19);
    wr(ra(0, 2), 32'h2);
    wr(ra(0, 3), 32'h2);
    wr(ra(0, 4), 32'h2000);
    wr(ra(0, 5), 32'h3000);
    wr(ra(0, 0), 32'hB5);
    per_req <= 4'h1;
    wait_flag(0, 1);
    per_req <= 4'h0;
    chk("busy cleared", 32'h0, {31'h0, rd_q[0]});
    for (int i = 0; i < 4; i++) chk("sram copy", pat(16'h2000 + 16'(i % 2)), mdl_u.mem[16'h3000 + i]);
    chk("done irq", 32'h1, {31'h0, ch_irq[0]});
    wr(ra(0, 6), 32'h2);
    rd(ra(0, 6));
    chk("done cleared", 32'h0, {31'h0, rd_q[1]});
    chk("irq cleared", 32'h0, {31'h0, ch_irq[0]});
  endtask
  task automatic t_eeprom();
    wr(ra(1, 1), 32'h21);
    wr(ra(1, 2), 32'h3);
    wr(ra(1, 4), 32'h1000);
    wr(ra(1, 5), 32'h3100);
    wr(ra(1, 0), 32'h0D);
    wr(ra(1, 0), 32'h0F);
    wait_flag(1, 1);
    for (int i = 0; i < 3; i++) chk("eeprom copy", pat(16'h1000 + 16'(i)), mdl_u.mem[16'h3100 - i]);
    chk("no irq when disabled", 32'h0, {31'h0, ch_irq[1]});
  endtask
  // The first pass writes an I/O location, the second reads it back into SRAM.
  task automatic t_event_io();
    for (int p = 0; p < 2; p++) begin
      wr(ra(2, 6), 32'h2);
      wr(ra(2, 4), p ? 32'h0040 : 32'h2010);
      wr(ra(2, 5), p ? 32'h3200 : 32'h0040);
      wr(ra(2, 0), 32'h901);
      evt_req <= 4'h4;
      @(posedge aclk);
      evt_req <= 4'h0;
      wait_flag(2, 1);
      chk("io copy", pat(16'h2010), mdl_u.mem[p ? 16'h3200 : 16'h0040]);
    end
    chk("crc bytes", 32'h2, crc_n);
    chk("crc data", {24'h0, pat(16'h2010)}, {24'h0, crc_seen});
  endtask
  // Channel 0 finishes a two-byte transfer and hands over to channel 1.
  task automatic t_link();
    wr(ra(1, 6), 32'h2);
    wr(ra(1, 5), 32'h3400);
    wr(ra(1, 0), 32'h8C);
    wr(ra(0, 5), 32'h3300);
    per_req <= 4'h2;
    wr(ra(0, 0), 32'h1005);
    wr(ra(0, 0), 32'h1007);
    wait_flag(1, 1);
    per_req <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      if (i < 2) chk("first copy", pat(16'h2000 + 16'(i)), mdl_u.mem[16'h3300 + i]);
      chk("linked copy", pat(16'h1000 + 16'(i)), mdl_u.mem[16'h3400 - i]);
    end
  endtask
  task automatic t_bad_addr();
    wr(ra(3, 4), 32'h6000);
    wr(ra(3, 5), 32'h3000);
    wr(ra(3, 0), 32'h41);
    wr(ra(3, 0), 32'h43);
    wait_flag(3, 2);
    chk("error irq", 32'h1, {31'h0, ch_irq[3]});
    rd(ra(3, 0));
    chk("enable dropped", 32'h0, {31'h0, rd_q[0]});
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #10 aclk = ~aclk;
  always @(posedge aclk) begin
    if (crc_out.stb) crc_n++;
    if (crc_out.stb) crc_seen = crc_out.data;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_sram_repeat();
    t_eeprom();
    t_event_io();
    t_link();
    t_bad_addr();
    results();
  end
endmodule // test_qdm_top
